/* hw/mic_defs.svh */
// register offsets, field positions, reset values, vector address and sizes for the interrupt controller
`ifndef MIC_DEFS_SVH
`define MIC_DEFS_SVH

`define MIC_ADDR_EDGE 8'hbf
`define MIC_ADDR_FLAG 8'hc8
`define MIC_ADDR_EN 8'hc9
`define MIC_ADDR_STK 8'hdf

`define MIC_BIT_PIN 0
`define MIC_BIT_BT 4
`define MIC_BIT_TC 5
`define MIC_BIT_GLOBAL_EN 7
`define MIC_EDGE_LO 3
`define MIC_EDGE_HI 4

`define MIC_EDGE_RST 2'h2
`define MIC_STK_RST 2'h3
`define MIC_VECTOR 10'h008
`define MIC_PC_W 10
`define MIC_STK_DEPTH 4

`endif

/* hw/mic_irq_ctrl.sv */
// interrupt controller: enables, sticky flags, global enable, vectoring, wake latch, shadow buffer
//
// Functional notes
// - entering service clears the global enable to 0
// - return from service sets the global enable back to 1
// - taking an interrupt pushes return address, lowers stack level by 1, jumps to 8
// - enable register: pin bit 0, basic timer bit 4, timer/counter bit 5, reset 0
// - flag register: pin bit 0, basic timer bit 4, timer/counter bit 5, reset 0
// - flags stay set through vector entry; software clears them by writing 0
// - configured pin edge sets pin flag regardless of its enable
// - no vector while global enable (stack register bit 7) is 0; resets 0
// - edge field bits 4:3: 01 rise, 10 fall, 11 both; resets to falling
// - matching pin edge that wakes from power-down is latched and serviced first
// - the pin can wake the chip from power-down to normal mode
// - every basic timer overflow sets its flag regardless of enable
// - basic timer flag with enable 0 never causes a vector
// - save/restore copy accumulator and flags, less status bits, to one shadow level
// - every timer/counter overflow sets its flag regardless of enable
`timescale 1ns/1ps
`include "mic_defs.svh"
module mic_irq_ctrl (
   input wire logic clk,
   input wire logic resetn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic external_pin_irq,
   input wire logic basic_timer_ovf,
   input wire logic timer_counter_ovf,
   input wire logic insn_boundary,
   input wire logic [`MIC_PC_W-1:0] return_pc,
   input wire logic return_from_service,
   input wire logic powerdown_req,
   input wire logic save_req,
   input wire logic restore_req,
   input wire logic [7:0] acc_in,
   input wire logic [7:0] program_flag_in,
   output logic vector_take,
   output logic [`MIC_PC_W-1:0] pc_load,
   output logic pc_load_valid,
   output logic [7:0] acc_restore,
   output logic [7:0] program_flag_restore,
   output logic restore_valid,
   output logic asleep,
   output logic [1:0] stack_level
);
   // timeout and power-down status bits of the program flag register stay out of the shadow copy
   localparam logic [7:0] STATUS_MASK = 8'hc0;

   // ****************************************
   // pin synchroniser and edge detection
   // ****************************************
   logic s1_r, s2_r, s3_r, pin_lvl_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_r <= 1'h1;
         s2_r <= 1'h1;
         s3_r <= 1'h1;
         pin_lvl_r <= 1'h1;
      end else begin
         s1_r <= external_pin_irq;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            pin_lvl_r <= s3_r;
         end
      end
   end

   logic [1:0] edge_mode_r;
   wire stable = (s2_r == s3_r);
   wire rise = stable && s3_r && !pin_lvl_r;
   wire fall = stable && !s3_r && pin_lvl_r;
   wire pin_match = (rise && edge_mode_r[0]) || (fall && edge_mode_r[1]);

   // ****************************************
   // register decode
   // ****************************************
   wire wr_edge = reg_wr && (reg_addr == `MIC_ADDR_EDGE);
   wire wr_flag = reg_wr && (reg_addr == `MIC_ADDR_FLAG);
   wire wr_en = reg_wr && (reg_addr == `MIC_ADDR_EN);
   wire wr_stk = reg_wr && (reg_addr == `MIC_ADDR_STK);

   logic [2:0] en_r, flag_r;
   logic global_irq_enable_r;
   logic [1:0] lvl_r;
   mic_pkg::mic_state_t st_r, st_nxt;
   logic wake_latch_r;

   wire [2:0] events = {timer_counter_ovf, basic_timer_ovf, pin_match};
   wire [2:0] flag_wr_val = {reg_wdata[`MIC_BIT_TC], reg_wdata[`MIC_BIT_BT], reg_wdata[`MIC_BIT_PIN]};
   // set beats a same-cycle software clear; vector entry never touches the flags
   wire [2:0] flag_nxt = (wr_flag ? flag_wr_val : flag_r) | events;
   wire pending = |(en_r & flag_r);
   wire take = (st_r == mic_pkg::MIC_RUN) && insn_boundary && global_irq_enable_r
      && (pending || wake_latch_r);

   // ****************************************
   // control registers
   // ****************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         en_r <= 3'h0;
         flag_r <= 3'h0;
         edge_mode_r <= `MIC_EDGE_RST;
      end else begin
         flag_r <= flag_nxt;
         if (wr_en) begin
            en_r <= flag_wr_val;
         end
         if (wr_edge) begin
            edge_mode_r <= reg_wdata[`MIC_EDGE_HI:`MIC_EDGE_LO];
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         global_irq_enable_r <= 1'h0;
         lvl_r <= `MIC_STK_RST;
      end else if (take) begin
         global_irq_enable_r <= 1'h0;
         lvl_r <= lvl_r - 2'h1;
      end else if (return_from_service) begin
         global_irq_enable_r <= 1'h1;
         lvl_r <= lvl_r + 2'h1;
      end else if (wr_stk) begin
         global_irq_enable_r <= reg_wdata[`MIC_BIT_GLOBAL_EN];
         lvl_r <= reg_wdata[1:0];
      end
   end

   // ****************************************
   // power-down and wake
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         mic_pkg::MIC_RUN: begin
            if (take) begin
               st_nxt = mic_pkg::MIC_ENTER;
            end else if (powerdown_req) begin
               st_nxt = mic_pkg::MIC_SLEEP;
            end
         end
         mic_pkg::MIC_ENTER: begin
            st_nxt = mic_pkg::MIC_RUN;
         end
         mic_pkg::MIC_SLEEP: begin
            if (rise || fall) begin
               st_nxt = mic_pkg::MIC_RUN;
            end
         end
         default: begin
            st_nxt = mic_pkg::MIC_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= mic_pkg::MIC_RUN;
         wake_latch_r <= 1'h0;
      end else begin
         st_r <= st_nxt;
         // a matching wake edge forces service first even when the pin enable is off
         if (st_r == mic_pkg::MIC_SLEEP && pin_match) begin
            wake_latch_r <= 1'h1;
         end else if (take) begin
            wake_latch_r <= 1'h0;
         end
      end
   end

   // ****************************************
   // stack and vector outputs
   // ****************************************
   wire [1:0] push_addr = lvl_r - 2'h1;
   wire [1:0] pop_addr = lvl_r;
   logic [`MIC_PC_W-1:0] stk_rd;
   mic_stack u_mic_stack (
      .clk(clk),
      .resetn(resetn),
      .wr_en(take),
      .wr_addr(push_addr),
      .wr_data(return_pc),
      .rd_addr(pop_addr),
      .rd_data(stk_rd)
   );

   logic ret_d_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         vector_take <= 1'h0;
         pc_load <= 10'h000;
         pc_load_valid <= 1'h0;
         ret_d_r <= 1'h0;
      end else begin
         vector_take <= take;
         ret_d_r <= return_from_service && !take;
         pc_load_valid <= take || ret_d_r;
         if (take) begin
            pc_load <= `MIC_VECTOR;
         end else if (ret_d_r) begin
            pc_load <= stk_rd;
         end
      end
   end

   // ****************************************
   // one-level shadow buffer
   // ****************************************
   logic [7:0] sh_acc_r, sh_flag_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sh_acc_r <= 8'h00;
         sh_flag_r <= 8'h00;
         acc_restore <= 8'h00;
         program_flag_restore <= 8'h00;
         restore_valid <= 1'h0;
      end else begin
         if (save_req) begin
            sh_acc_r <= acc_in;
            sh_flag_r <= program_flag_in & ~STATUS_MASK;
         end
         restore_valid <= restore_req;
         if (restore_req) begin
            acc_restore <= sh_acc_r;
            program_flag_restore <= (program_flag_in & STATUS_MASK) | sh_flag_r;
         end
      end
   end

   // ****************************************
   // readback
   // ****************************************
   wire [7:0] rd_val =
      (reg_addr == `MIC_ADDR_EDGE) ? {3'h0, edge_mode_r, 3'h0} :
      (reg_addr == `MIC_ADDR_FLAG) ? {2'h0, flag_r[2], flag_r[1], 3'h0, flag_r[0]} :
      (reg_addr == `MIC_ADDR_EN) ? {2'h0, en_r[2], en_r[1], 3'h0, en_r[0]} :
      (reg_addr == `MIC_ADDR_STK) ? {global_irq_enable_r, 5'h00, lvl_r} : 8'h00;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
         asleep <= 1'h0;
         stack_level <= `MIC_STK_RST;
      end else begin
         reg_rdata <= reg_rd ? rd_val : 8'h00;
         asleep <= (st_nxt == mic_pkg::MIC_SLEEP);
         stack_level <= lvl_r;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   property p_glob_clear;
      @(posedge clk) disable iff (!resetn) take |=> !global_irq_enable_r;
   endproperty
   a_glob_clear: assert property (p_glob_clear) else $error("global enable not cleared on entry");

   property p_glob_set;
      @(posedge clk) disable iff (!resetn) (return_from_service && !take) |=> global_irq_enable_r;
   endproperty
   a_glob_set: assert property (p_glob_set) else $error("global enable not set on return");

   property p_vector;
      @(posedge clk) disable iff (!resetn) take |=> (pc_load == `MIC_VECTOR) && pc_load_valid && vector_take;
   endproperty
   a_vector: assert property (p_vector) else $error("vector not loaded");

   property p_no_take_off;
      @(posedge clk) disable iff (!resetn) !global_irq_enable_r |=> !vector_take;
   endproperty
   a_no_take_off: assert property (p_no_take_off) else $error("vector taken with global enable off");

   property p_bt_set;
      @(posedge clk) disable iff (!resetn) basic_timer_ovf |=> flag_r[1];
   endproperty
   a_bt_set: assert property (p_bt_set) else $error("basic timer flag not set");

   property p_tc_set;
      @(posedge clk) disable iff (!resetn) (timer_counter_ovf && wr_flag) |=> flag_r[2];
   endproperty
   a_tc_set: assert property (p_tc_set) else $error("timer/counter set lost to clear");

   property p_sticky;
      @(posedge clk) disable iff (!resetn) (take && !wr_flag) |=> flag_r == $past(flag_r | events);
   endproperty
   a_sticky: assert property (p_sticky) else $error("flags changed on vector entry");

   property p_pin_flag;
      @(posedge clk) disable iff (!resetn) pin_match |=> flag_r[0];
   endproperty
   a_pin_flag: assert property (p_pin_flag) else $error("pin edge lost");

   property p_bt_masked;
      @(posedge clk) disable iff (!resetn)
         (global_irq_enable_r && flag_r[1] && !en_r[1] && !wake_latch_r
            && !(en_r[0] && flag_r[0]) && !(en_r[2] && flag_r[2])) |-> !take;
   endproperty
   a_bt_masked: assert property (p_bt_masked) else $error("vector for a masked basic timer flag");
endmodule

/* hw/mic_pkg.sv */
// types shared by the interrupt controller
package mic_pkg;
   typedef enum logic [1:0] {
      MIC_EDGE_RSVD = 2'h0,
      MIC_EDGE_RISE = 2'h1,
      MIC_EDGE_FALL = 2'h2,
      MIC_EDGE_BOTH = 2'h3
   } mic_edge_t;
   typedef enum logic [1:0] {
      MIC_RUN = 2'h0,
      MIC_ENTER = 2'h1,
      MIC_SLEEP = 2'h3
   } mic_state_t;
endpackage

/* hw/mic_stack.sv */
// return address stack memory with registered read data
`timescale 1ns/1ps
`include "mic_defs.svh"
module mic_stack (
   input wire logic clk,
   input wire logic resetn,
   input wire logic wr_en,
   input wire logic [1:0] wr_addr,
   input wire logic [`MIC_PC_W-1:0] wr_data,
   input wire logic [1:0] rd_addr,
   output logic [`MIC_PC_W-1:0] rd_data
);
   logic [`MIC_PC_W-1:0] mem [`MIC_STK_DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_data <= 10'h000;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

/* tb/mic_core_model.sv */
// core sequencer model: instruction boundaries, return addresses and return commands
`timescale 1ns/1ps
`include "mic_defs.svh"
module mic_core_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic slow,
   input wire logic ret_req,
   input wire logic vector_take,
   output logic insn_boundary,
   output logic [`MIC_PC_W-1:0] return_pc,
   output logic return_from_service
);
   // the jump to the vector costs a cycle, so no boundary right after a take
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         insn_boundary <= 1'b0;
         return_pc <= 10'h100;
         return_from_service <= 1'b0;
      end else begin
         insn_boundary <= ~vector_take & (~slow | ~insn_boundary);
         return_pc <= return_pc + {9'h000, vector_take};
         return_from_service <= ret_req;
      end
   end
endmodule

/* tb/mic_irq_ctrl_bench.sv */
// bench for the interrupt controller: reference model with a core partner
`timescale 1ns/1ps
`include "mic_defs.svh"
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_fail++; \
   $display("BAD %s exp %0h got %0h", nm, e, s); end end
module mic_irq_ctrl_bench;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, pin_v = 1'b1, bt = 1'b0, tc = 1'b0;
   logic pd = 1'b0, sv = 1'b0, rs = 1'b0, ret_req = 1'b0, slow = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, acc_in = 8'h00, pf_in = 8'h00;
   logic [7:0] reg_rdata, acc_o, pf_o;
   logic ib, rfs, vt, plv, rv, asleep;
   logic [`MIC_PC_W-1:0] ret_pc, pc_load, last_pc;
   logic [1:0] lvl;
   logic [7:0] regs[4] = '{`MIC_ADDR_EDGE, `MIC_ADDR_FLAG, `MIC_ADDR_EN, `MIC_ADDR_STK};
   int n_fail = 0, checks = 0, n_vec = 0;
   int en = 0, flg = 0, glob_en = 0, edg = 2;
   int stk[$];
   initial forever #5 clk = ~clk;
   mic_irq_ctrl u_mic_irq_ctrl (.clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .external_pin_irq(pin_v),
      .basic_timer_ovf(bt), .timer_counter_ovf(tc), .insn_boundary(ib), .return_pc(ret_pc),
      .return_from_service(rfs), .powerdown_req(pd), .save_req(sv), .restore_req(rs), .acc_in(acc_in),
      .program_flag_in(pf_in), .vector_take(vt), .pc_load(pc_load), .pc_load_valid(plv),
      .acc_restore(acc_o), .program_flag_restore(pf_o), .restore_valid(rv), .asleep(asleep),
      .stack_level(lvl));
   mic_core_model u_mic_core_model (.clk(clk), .resetn(resetn), .slow(slow), .ret_req(ret_req),
      .vector_take(vt), .insn_boundary(ib), .return_pc(ret_pc), .return_from_service(rfs));
   // model side of a vector: push the address the core offered, global enable drops
   always @(posedge clk) begin
      if (vt === 1'b1) begin
         stk.push_back(10'h100 + n_vec);
         n_vec++;
         glob_en = 0;
      end
      if (plv === 1'b1) last_pc <= pc_load;
   end
   task automatic complete_run;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      complete_run();
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      if (a == `MIC_ADDR_EN) en = d & 8'h31;
      if (a == `MIC_ADDR_FLAG) flg = flg & d;
      if (a == `MIC_ADDR_STK) glob_en = d[7];
      if (a == `MIC_ADDR_EDGE) edg = d[4:3];
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      `CHK("rdata", e & m, reg_rdata & m)
   endtask
   task automatic chk_reg(input logic [7:0] a);
      logic [7:0] e;
      logic [7:0] m;
      e = (a == `MIC_ADDR_EDGE) ? 8'(edg << 3) : (a == `MIC_ADDR_STK) ? {glob_en[0], 5'h00, 2'(3 - stk.size())} :
         (a == `MIC_ADDR_EN) ? 8'(en) : 8'(flg);
      m = (a == `MIC_ADDR_EDGE) ? 8'h18 : (a == `MIC_ADDR_STK) ? 8'h83 : 8'h31;
      rd(a, m, e);
   endtask
   task automatic ovf(input int which);
      @(negedge clk);
      bt = (which == 0);
      tc = (which != 0);
      @(negedge clk);
      bt = 1'b0;
      tc = 1'b0;
      flg = flg | ((which == 0) ? 8'h10 : 8'h20);
   endtask
   task automatic pin(input logic v);
      @(negedge clk);
      pin_v = v;
      if ((v && edg[0]) || (!v && edg[1])) flg = flg | 1;
   endtask
   task automatic settle;
      int v0;
      int want;
      v0 = n_vec;
      want = (glob_en != 0 && (en & flg) != 0) ? 1 : 0;
      repeat (12) @(negedge clk);
      `CHK("vectors", v0 + want, n_vec)
      if (want != 0) `CHK("vector pc", 10'h008, last_pc)
      `CHK("level", 2'(3 - stk.size()), lvl)
   endtask
   // service checks stack and flags, clears every flag, returns and checks the return address
   task automatic svc;
      logic [9:0] p;
      chk_reg(`MIC_ADDR_STK);
      chk_reg(`MIC_ADDR_FLAG);
      if (flg[4]) repeat (1600) @(negedge clk);
      wr(`MIC_ADDR_FLAG, 8'h00);
      @(negedge clk);
      ret_req = 1'b1;
      @(negedge clk);
      ret_req = 1'b0;
      glob_en = 1;
      p = 10'(stk.pop_back());
      repeat (6) @(negedge clk);
      `CHK("return pc", p, last_pc)
      chk_reg(`MIC_ADDR_STK);
   endtask
   initial begin
      logic [7:0] a;
      logic [7:0] f;
      int v;
      void'($urandom(42));
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      foreach (regs[i]) chk_reg(regs[i]);
      rd(8'ha0, 8'hff, 8'h00);
      wr(`MIC_ADDR_EN, 8'($urandom));
      chk_reg(`MIC_ADDR_EN);
      wr(`MIC_ADDR_EN, 8'h00);
      wr(`MIC_ADDR_STK, 8'h83);
      ovf(0);
      settle;
      ovf(1);
      settle;
      chk_reg(`MIC_ADDR_FLAG);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = `MIC_ADDR_FLAG;
      reg_wdata = 8'h00;
      bt = 1'b1;
      tc = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      bt = 1'b0;
      tc = 1'b0;
      flg = 8'h30;
      chk_reg(`MIC_ADDR_FLAG);
      wr(`MIC_ADDR_FLAG, 8'h00);
      for (int s = 0; s < 2; s++) begin
         slow = s[0];
         wr(`MIC_ADDR_STK, 8'h03);
         wr(`MIC_ADDR_EN, 8'h30);
         ovf(s);
         settle;
         wr(`MIC_ADDR_STK, 8'h83);
         settle;
         svc;
      end
      wr(`MIC_ADDR_EN, 8'h00);
      for (int m = 0; m < 4; m++) begin
         wr(`MIC_ADDR_EDGE, 8'(m << 3));
         pin(1'b0);
         settle;
         chk_reg(`MIC_ADDR_FLAG);
         pin(1'b1);
         settle;
         chk_reg(`MIC_ADDR_FLAG);
         wr(`MIC_ADDR_FLAG, 8'h00);
      end
      wr(`MIC_ADDR_EDGE, 8'h10);
      @(negedge clk);
      pd = 1'b1;
      @(negedge clk);
      pd = 1'b0;
      repeat (3) @(negedge clk);
      `CHK("asleep", 1'b1, asleep)
      v = n_vec;
      pin(1'b0);
      repeat (12) @(negedge clk);
      `CHK("asleep", 1'b0, asleep)
      `CHK("wake vectors", v + 1, n_vec)
      svc;
      pin(1'b1);
      repeat (3) begin
         a = 8'($urandom);
         f = 8'($urandom);
         @(negedge clk);
         sv = 1'b1;
         acc_in = a;
         pf_in = f;
         @(negedge clk);
         sv = 1'b0;
         acc_in = ~a;
         pf_in = ~f;
         rs = 1'b1;
         @(negedge clk);
         `CHK("restore valid", 1'b1, rv)
         `CHK("acc", a, acc_o)
         `CHK("flags", f & 8'h3f, pf_o & 8'h3f)
         `CHK("status", ~f & 8'hc0, pf_o & 8'hc0)
         rs = 1'b0;
      end
      complete_run();
   end
endmodule
